/* File: irc_pkg.sv */
// constants shared by the infrared control block
// assumes a 32-bit avalon-mm slave port and synchronous pins
`default_nettype none
package irc_pkg;
	// register byte offsets
	localparam logic [3:0] IRC_CTRL_OFS = 4'h0;
	localparam logic [3:0] IRC_STAT_OFS = 4'h4;
	// control field positions
	localparam int IRC_EN_BIT    = 0;
	localparam int IRC_DIR_BIT   = 1;
	localparam int IRC_POL_BIT   = 2;
	localparam int IRC_MOD_BIT   = 3;
	localparam int IRC_RXSEL_LO  = 4;
	localparam int IRC_ENV_LO    = 8;
	// status field positions
	localparam int IRC_ST_TX_BIT  = 0;
	localparam int IRC_ST_ENV_BIT = 1;
	localparam int IRC_ST_RX_BIT  = 2;
	localparam int IRC_ST_CAP_BIT = 3;
	// reset value and writable bits of the control word, and reset value of the status word
	localparam logic [15:0] IRC_CTRL_RST   = 16'h0000;
	localparam logic [15:0] IRC_CTRL_WMASK = 16'h033F;
	localparam logic [3:0]  IRC_STAT_RST   = 4'h0;
	// receive edge choices
	typedef enum logic [1:0] {
		IRC_EDGE_FALL = 2'h0,
		IRC_EDGE_RISE = 2'h1,
		IRC_EDGE_BOTH = 2'h2,
		IRC_EDGE_NONE = 2'h3
	} irc_edge_t;
	// envelope output modes
	typedef enum logic [1:0] {
		IRC_ENV_OFF = 2'h0,
		IRC_ENV_A   = 2'h1,
		IRC_ENV_B   = 2'h2,
		IRC_ENV_RSV = 2'h3
	} irc_env_t;
	// bus handshake states, one-hot
	typedef enum logic [1:0] {
		IRC_BUS_IDLE = 2'b01,
		IRC_BUS_ACK  = 2'b10
	} irc_bus_t;
endpackage
`default_nettype wire

/* File: irc_edge_detect.sv */
// receive edge qualifier for the infrared control block
// assumes the receive pin is already synchronous to ref_clk
`default_nettype none
module irc_edge_detect
	import irc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       level,
	input  wire logic [1:0] edge_sel,
	input  wire logic       arm,
	output logic            capture,
	output logic            last_level
);
	logic rose;
	logic fell;

	// previous level, tracked even when unarmed so arming sees no false edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			last_level <= 1'b0;
		end else begin
			last_level <= level;
		end
	end

	assign rose = level & ~last_level;
	assign fell = ~level & last_level;

	// edge choice decode
	always_comb begin
		capture = 1'b0;
		if (arm) begin
			case (irc_edge_t'(edge_sel))
				IRC_EDGE_FALL: capture = fell;
				IRC_EDGE_RISE: capture = rose;
				IRC_EDGE_BOTH: capture = rose | fell;
				default:       capture = 1'b0;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	reserved_no_edge_a: assert property (edge_sel == 2'h3 |-> !capture)
		else $error("capture seen with edge detection disabled");
	fall_edge_a: assert property (arm && edge_sel == 2'h0 && $fell(level) |-> capture)
		else $error("falling edge not captured");
	rise_only_a: assert property (edge_sel == 2'h1 && capture |-> $rose(level))
		else $error("rising choice captured a non-rising edge");
	both_edge_a: assert property (arm && edge_sel == 2'h2 && level != $past(level)
		|-> capture)
		else $error("edge missed in both-edge choice");
endmodule
`default_nettype wire

/* File: irc_tx_drive.sv */
// output stage: carrier pin and envelope pin, both registered
// assumes carrier arrives from an outside generator, synchronous to ref_clk
`default_nettype none
module irc_tx_drive
	import irc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       unit_on,
	input  wire logic       transmit_mode,
	input  wire logic       polarity,
	input  wire logic       modulation,
	input  wire logic [1:0] env_mode,
	input  wire logic       carrier,
	output logic            carrier_pin,
	output logic            envelope_pin
);
	// carrier gating; idle level is the polarity bit itself
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			carrier_pin <= 1'b0;
		end else if (!unit_on) begin
			carrier_pin <= 1'b0;
		end else if (transmit_mode && modulation) begin
			carrier_pin <= carrier ^ polarity;
		end else begin
			carrier_pin <= polarity;
		end
	end

	// envelope follows the modulation bit, flipped by polarity
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			envelope_pin <= 1'b0;
		end else if (unit_on && (env_mode == IRC_ENV_A || env_mode == IRC_ENV_B)) begin
			envelope_pin <= modulation ^ polarity;
		end else begin
			envelope_pin <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: irc_top.sv */
// infrared control block: control register, capture and output drive
// assumes an avalon-mm master with waitrequest and synchronous pins;
// the carrier generator sits outside and feeds carrier_in
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none

module irc_top
	import irc_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              carrier_in,
	input  wire logic              receive_input_pin,
	output logic                   carrier_output_pin,
	output logic                   envelope_output_pin
);
	irc_bus_t    bus_state;
	logic [15:0] infrared_control;
	logic [15:0] next_control;
	logic        capture_seen;
	logic        capture;
	logic        rx_last;
	logic        access;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        infrared_unit_enable;
	logic        direction_select;
	logic        transmit_polarity;
	logic        modulation_bit;
	logic [1:0]  receive_edge_select;
	logic [1:0]  envelope_output_mode;
	logic [31:0] read_word;

	// field views of the control word
	assign infrared_unit_enable = infrared_control[IRC_EN_BIT];
	assign direction_select     = infrared_control[IRC_DIR_BIT];
	assign transmit_polarity    = infrared_control[IRC_POL_BIT];
	assign modulation_bit       = infrared_control[IRC_MOD_BIT];
	assign receive_edge_select  = infrared_control[IRC_RXSEL_LO+1:IRC_RXSEL_LO];
	assign envelope_output_mode = infrared_control[IRC_ENV_LO+1:IRC_ENV_LO];

	// offset match, shared by read and write paths
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
		addr_is = (a == ADDR_W'(ofs));
	endfunction

	// the access completes at the edge where waitrequest is seen low
	assign access  = bus_state == IRC_BUS_ACK;
	assign wr_ctrl = access && avs_write && addr_is(avs_address, IRC_CTRL_OFS);
	assign wr_stat = access && avs_write && addr_is(avs_address, IRC_STAT_OFS);

	// bus handshake: one wait cycle, then the answer for one cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus_state       <= IRC_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state)
				IRC_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state       <= IRC_BUS_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				IRC_BUS_ACK: begin
					bus_state       <= IRC_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state       <= IRC_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		read_word = 32'h0000_0000;
		if (addr_is(avs_address, IRC_CTRL_OFS)) begin
			read_word[15:0] = infrared_control;
		end else if (addr_is(avs_address, IRC_STAT_OFS)) begin
			read_word[IRC_ST_TX_BIT]  = carrier_output_pin;
			read_word[IRC_ST_ENV_BIT] = envelope_output_pin;
			read_word[IRC_ST_RX_BIT]  = rx_last;
			read_word[IRC_ST_CAP_BIT] = capture_seen;
		end
	end

	// read data is latched as waitrequest falls and holds until the next read
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (bus_state == IRC_BUS_IDLE && avs_read) begin
			avs_readdata <= read_word;
		end
	end

	// next control word: byte-lane writes, then hardware capture on top
	always_comb begin
		next_control = infrared_control;
		if (wr_ctrl && avs_byteenable[0]) begin
			next_control[7:0] = avs_writedata[7:0] & IRC_CTRL_WMASK[7:0];
		end
		if (wr_ctrl && avs_byteenable[1]) begin
			next_control[15:8] = avs_writedata[15:8] & IRC_CTRL_WMASK[15:8];
		end
		// capture beats a same-cycle software write so no sample is lost
		if (capture) begin
			next_control[IRC_MOD_BIT] = receive_input_pin;
		end
	end

	// control register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			infrared_control <= IRC_CTRL_RST;
		end else begin
			infrared_control <= next_control;
		end
	end

	// sticky capture flag, write one to clear; a new capture wins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			capture_seen <= IRC_STAT_RST[IRC_ST_CAP_BIT];
		end else if (capture) begin
			capture_seen <= 1'b1;
		end else if (wr_stat && avs_byteenable[0] && avs_writedata[IRC_ST_CAP_BIT]) begin
			capture_seen <= 1'b0;
		end
	end

	// capture armed only when enabled and receiving
	irc_edge_detect u_edge (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.level      (receive_input_pin),
		.edge_sel   (receive_edge_select),
		.arm        (infrared_unit_enable && !direction_select),
		.capture    (capture),
		.last_level (rx_last)
	);

	// pin drive; transmit gating lives in the output stage
	irc_tx_drive u_drive (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.unit_on       (infrared_unit_enable),
		.transmit_mode (direction_select),
		.polarity      (transmit_polarity),
		.modulation    (modulation_bit),
		.env_mode      (envelope_output_mode),
		.carrier       (carrier_in),
		.carrier_pin   (carrier_output_pin),
		.envelope_pin  (envelope_output_pin)
	);

	// checks on the block's own behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_request;
		bus_state == IRC_BUS_IDLE && (avs_read || avs_write);
	endsequence

	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	bus_answer_a: assert property (s_request |=> s_answer)
		else $error("waitrequest did not drop for one cycle");

	read_data_a: assert property (s_request ##0 avs_read
		##0 addr_is(avs_address, IRC_CTRL_OFS)
		|=> avs_readdata[15:0] == $past(infrared_control))
		else $error("control read data wrong");

	unit_off_a: assert property (!infrared_unit_enable
		|=> !carrier_output_pin && !envelope_output_pin)
		else $error("outputs active while unit disabled");

	rx_no_load_a: assert property (infrared_unit_enable && direction_select && !wr_ctrl
		|=> $stable(modulation_bit))
		else $error("modulation bit changed in transmit mode");

	rx_idle_a: assert property (infrared_unit_enable && !direction_select
		|=> carrier_output_pin == $past(transmit_polarity))
		else $error("receive mode idle level wrong");

	env_plain_a: assert property (infrared_unit_enable && !transmit_polarity
		&& (envelope_output_mode == 2'h1 || envelope_output_mode == 2'h2)
		|=> envelope_output_pin == $past(modulation_bit))
		else $error("envelope does not follow modulation bit");

	env_invert_a: assert property (infrared_unit_enable && transmit_polarity
		&& (envelope_output_mode == 2'h1 || envelope_output_mode == 2'h2)
		|=> envelope_output_pin != $past(modulation_bit))
		else $error("envelope not inverted under polarity one");

	carrier_pass_a: assert property (infrared_unit_enable && direction_select
		&& modulation_bit
		|=> carrier_output_pin == ($past(carrier_in) ^ $past(transmit_polarity)))
		else $error("carrier not passed to output");

	tx_idle_a: assert property (infrared_unit_enable && direction_select
		&& !modulation_bit
		|=> carrier_output_pin == $past(transmit_polarity))
		else $error("idle level differs from polarity");

	capture_load_a: assert property (capture
		|=> modulation_bit == $past(receive_input_pin) && capture_seen)
		else $error("capture did not load receive level");

	edge_field_a: assert property (capture
		|-> receive_edge_select != 2'h3 && infrared_unit_enable && !direction_select)
		else $error("capture outside armed receive mode");

	// the handshake state stays one-hot and waitrequest mirrors it
	bus_onehot_a: assert property ($onehot(bus_state))
		else $error("bus state not one-hot");

	wait_state_a: assert property (avs_waitrequest == (bus_state == IRC_BUS_IDLE))
		else $error("waitrequest disagrees with bus state");

	read_hold_a: assert property (!(bus_state == IRC_BUS_IDLE && avs_read)
		|=> $stable(avs_readdata))
		else $error("read data moved without a read");

	sequence s_stat_read;
		s_request ##0 avs_read ##0 addr_is(avs_address, IRC_STAT_OFS);
	endsequence

	sequence s_void_read;
		s_request ##0 avs_read ##0 !addr_is(avs_address, IRC_CTRL_OFS)
			##0 !addr_is(avs_address, IRC_STAT_OFS);
	endsequence

	stat_read_a: assert property (s_stat_read
		|=> avs_readdata[31:4] == 28'h0000000
		&& avs_readdata[3:0] == $past({capture_seen, rx_last, envelope_output_pin,
			carrier_output_pin}))
		else $error("status read data wrong");

	void_read_a: assert property (s_void_read |=> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// reserved control bits can never be set, by software or by capture
	ctrl_mask_a: assert property ((infrared_control & ~IRC_CTRL_WMASK) == 16'h0000)
		else $error("reserved control bit set");

	ctrl_write_a: assert property (wr_ctrl && avs_byteenable[1:0] == 2'b11 && !capture
		|=> infrared_control == $past(avs_writedata[15:0] & IRC_CTRL_WMASK))
		else $error("control write did not land");

	ctrl_keep_a: assert property (!wr_ctrl && !capture |=> $stable(infrared_control))
		else $error("control changed with no write or capture");

	flag_clear_a: assert property (wr_stat && avs_byteenable[0]
		&& avs_writedata[IRC_ST_CAP_BIT] && !capture |=> !capture_seen)
		else $error("capture flag not cleared");

	flag_hold_a: assert property (capture_seen && !wr_stat |=> capture_seen)
		else $error("capture flag lost");

	rx_track_a: assert property (1'b1 |=> rx_last == $past(receive_input_pin))
		else $error("receive level history wrong");

	rx_keep_a: assert property (infrared_unit_enable && !direction_select
		&& !capture && !wr_ctrl |=> $stable(modulation_bit))
		else $error("modulation bit changed without capture");

	tx_no_capture_a: assert property (direction_select |-> !capture)
		else $error("capture in transmit mode");

	off_no_capture_a: assert property (!infrared_unit_enable |-> !capture)
		else $error("capture with unit disabled");

	env_off_a: assert property (!(infrared_unit_enable
		&& (envelope_output_mode == 2'h1 || envelope_output_mode == 2'h2))
		|=> !envelope_output_pin)
		else $error("envelope active while its mode is off");
endmodule
`default_nettype wire

/* File: irc_ir_model.sv */
// emitter and detector side of the infrared control block
// assumes the bench steers the carrier generator and the detector level
`default_nettype none
module irc_ir_model #(
	parameter int HALF = 1
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic carrier_run,
	input  wire logic rx_level,
	output logic      carrier_in,
	output logic      receive_input_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt;
	// carrier toggles every HALF cycles, rests low when stopped
	always_ff @(posedge ref_clk) begin
		if (rst || !carrier_run) begin
			carrier_in <= 1'b0;
			cnt        <= 0;
		end else if (cnt == HALF - 1) begin
			carrier_in <= ~carrier_in;
			cnt        <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// detector drives its line at all times, no release
	assign receive_input_pin = rx_level;
endmodule
`default_nettype wire

/* File: test_infrared_tx_rx_control.sv */
// self-checking bench for the infrared control block
// assumes irc_pkg, irc_top and the emitter model are compiled first
`default_nettype none
module test_infrared_tx_rx_control;
	timeunit 1ns;
	timeprecision 100ps;
	import irc_pkg::*;
	logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, run = 0, rx = 0, car_q;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, carrier_in, rx_pin, tx_pin, env_pin, pol, md, re, fe;
	logic [1:0] env, sel;
	int error_cnt = 0, compares = 0, cyc = 0;
	irc_top DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .carrier_in(carrier_in),
		.receive_input_pin(rx_pin), .carrier_output_pin(tx_pin),
		.envelope_output_pin(env_pin));
	irc_ir_model IR (.ref_clk(ref_clk), .rst(rst), .carrier_run(run), .rx_level(rx),
		.carrier_in(carrier_in), .receive_input_pin(rx_pin));
	// clock and cycle ceiling; the whole run needs a few hundred cycles
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		car_q <= carrier_in;
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t word %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t pin %b want %b", $time, got, exp);
		end
	endtask
	// one bus cycle; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !wr;
		avs_write     <= wr;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (n == 20)
			chk_word(32'hFFFFFFFF, 32'h0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		run <= 1'b1;
		bus(0, IRC_CTRL_OFS, 0); chk_word(rd, 32'(IRC_CTRL_RST));
		bus(0, IRC_STAT_OFS, 0); chk_word(rd, 32'(IRC_STAT_RST));
		// unused bits must stay zero after a write of all ones except the enable and modulation bits
		bus(1, IRC_CTRL_OFS, 32'h0000FFF6);
		bus(0, IRC_CTRL_OFS, 0); chk_word(rd, 32'h00000336);
		// unit off: pins stay low whatever else is set
		settle(2); chk_pin(tx_pin, 1'b0);
		chk_pin(env_pin, 1'b0);
		bus(1, 4'hC, 32'h00000001);
		bus(0, 4'hC, 0); chk_word(rd, 32'h0);
		bus(0, IRC_CTRL_OFS, 0); chk_word(rd, 32'h00000336);
		// transmit: every polarity, data bit and envelope mode
		for (int i = 0; i < 16; i++) begin
			pol = i[0];
			md  = i[1];
			env = 2'(i >> 2);
			bus(1, IRC_CTRL_OFS, {22'h0, env, 4'h0, md, pol, 2'b11});
			settle(2);
			for (int k = 0; k < 2; k++) begin
				chk_pin(tx_pin, md ? (car_q ^ pol) : pol);
				chk_pin(env_pin, (env == 2'h1 || env == 2'h2) ? (md ^ pol) : 1'b0);
				settle(1);
			end
		end
		// receive: each edge choice against a rise then a fall
		for (int s = 0; s < 4; s++) begin
			sel = 2'(s);
			pol = sel[0];
			re  = (sel == 2'h1 || sel == 2'h2);
			fe  = (sel == 2'h0 || sel == 2'h2);
			bus(1, IRC_CTRL_OFS, {26'h0, sel, 1'b0, pol, 2'b01});
			bus(1, IRC_STAT_OFS, 32'h8);
			settle(1); chk_pin(tx_pin, pol);
			@(posedge ref_clk);
			rx <= 1'b1;
			settle(3);
			bus(0, IRC_CTRL_OFS, 0); chk_pin(rd[IRC_MOD_BIT], re);
			bus(0, IRC_STAT_OFS, 0); chk_pin(rd[IRC_ST_CAP_BIT], re);
			bus(1, IRC_CTRL_OFS, {26'h0, sel, 1'b1, pol, 2'b01});
			bus(1, IRC_STAT_OFS, 32'h8);
			rx <= 1'b0;
			settle(3);
			bus(0, IRC_CTRL_OFS, 0); chk_pin(rd[IRC_MOD_BIT], !fe);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
